/* core/sipo_pkg.sv */
`default_nettype none

package sipo_pkg;

    localparam int         STAGE_COUNT = 8;
    localparam int         SYNC_DEPTH  = 3;
    localparam int         FIFO_DEPTH  = 8;
    localparam logic [7:0] STAGE_RST   = 8'h00;
    localparam logic [7:0] WORD_RST    = 8'h00;

    // pins driven by the upstream logic
    typedef struct packed {
        logic clrN;
        logic shiftClk;
        logic serA;
        logic serB;
    } pin_in_t;

    // parallel word handed out through the buffer
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } word_t;

endpackage

`default_nettype wire

/* core/serial_in_parallel_out_shift8.sv */
// Contract
// (R1) Eight flip-flop stages each drive their own parallel output always.
// (R2) A shift edge loads the AND of both serial inputs into stage one.
// (R3) While one serial input is high, the other alone decides stage one.
// (R4) Each shift edge with clear inactive moves every stage up by one.
// (R5) A low clear forces all eight stages low at once, clock or no clock.
// (R6) Without clear or shift edge the stages hold, whatever the inputs do.
// (R7) Only the serial input values present at the shift edge are captured.
// (R8) The last stage is the serial output, a bit shows there after 8 edges.
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// pin synchroniser

module sipo_pin_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // raw pins and agreed levels
    input  wire logic [WIDTH-1:0] pinRaw,
    output logic [WIDTH-1:0]      lvlNow,
    output logic [WIDTH-1:0]      lvlOld
);
    logic [WIDTH-1:0] sync1_r, sync2_r, sync3_r;
    logic [WIDTH-1:0] lvl_r, lvl_nxt;

    // a level moves only once the second and third stages agree
    always_comb begin
        lvl_nxt = lvl_r;
        for (int i = 0; i < WIDTH; i++) begin
            if (sync2_r[i] == sync3_r[i]) begin
                lvl_nxt[i] = sync3_r[i];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            lvl_r   <= '0;
        end else begin
            sync1_r <= pinRaw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            lvl_r   <= lvl_nxt;
        end
    end

    assign lvlNow = lvl_nxt;
    assign lvlOld = lvl_r;

endmodule // sipo_pin_sync

//////////////////////////////////////////////////////////////////////////////
// word buffer

module sipo_word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    // drain side
    output logic                  outValid,
    output logic [WIDTH-1:0]      outData,
    input  wire logic             outReady
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r   [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [AW-1:0]    wrPtr_r, wrPtr_nxt;
    logic [AW-1:0]    rdPtr_r, rdPtr_nxt;
    logic [AW:0]      count_r, count_nxt;
    logic             doPush, doPop;

    assign inReady  = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData  = mem_r[rdPtr_r];
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;

    always_comb begin
        mem_nxt   = mem_r;
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        count_nxt = count_r;
        if (doPush) begin
            mem_nxt[wrPtr_r] = inData;
            wrPtr_nxt = (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
        end
        if (doPop) begin
            rdPtr_nxt = (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
        end
        case ({doPush, doPop})
            2'b10:   count_nxt = count_r + 1'b1;
            2'b01:   count_nxt = count_r - 1'b1;
            default: count_nxt = count_r;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            mem_r   <= mem_nxt;
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            count_r <= count_nxt;
        end
    end

endmodule // sipo_word_fifo

//////////////////////////////////////////////////////////////////////////////
// shift register top

module serial_in_parallel_out_shift8 #(
    parameter int DEPTH = sipo_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // upstream pins
    input  wire sipo_pkg::pin_in_t pinIn,
    // stage outputs
    output logic [7:0]             parOut,
    output logic                   serOut,
    // buffered words
    output logic                   captureReady,
    output sipo_pkg::word_t        wordOut,
    input  wire logic              wordReady
);
    import sipo_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    pin_in_t    pinNow;
    pin_in_t    pinOld;
    logic       clkRise;
    logic       gateBit;
    logic       anyRstN;

    sipo_pin_sync #(
        .WIDTH ($bits(pin_in_t))
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pinRaw   (pinIn),
        .lvlNow   (pinNow),
        .lvlOld   (pinOld)
    );

    // one pulse per agreed low-to-high change
    assign clkRise = pinNow.shiftClk && !pinOld.shiftClk;    // see (R7)
    assign gateBit = pinNow.serA & pinNow.serB;              // see (R2) (R3)
    assign anyRstN = rst_n & pinIn.clrN;                     // see (R5)

    //////////////////////////////////////////////////////////////////////////
    // stages

    logic [STAGE_COUNT-1:0] stage_r, stage_nxt;

    always_comb begin
        stage_nxt = stage_r;                            // see (R6)
        if (clkRise) begin
            stage_nxt = {stage_r[STAGE_COUNT-2:0], gateBit}; // see (R2) (R4)
        end
    end

    always_ff @(posedge core_clk or negedge anyRstN) begin
        if (!anyRstN) begin
            stage_r <= STAGE_RST;                       // see (R5)
        end else begin
            stage_r <= stage_nxt;                       // see (R1)
        end
    end

    assign parOut = stage_r;                            // see (R1)
    assign serOut = stage_r[STAGE_COUNT-1];             // see (R8)

    //////////////////////////////////////////////////////////////////////////
    // word buffer and output stage

    logic       fifoInReady;
    logic       fifoOutValid;
    logic [7:0] fifoOutData;
    logic       fifoPop;
    logic       pushNow;
    logic       ready_r, ready_nxt;
    word_t      word_r, word_nxt;

    sipo_word_fifo #(
        .WIDTH (STAGE_COUNT),
        .DEPTH (DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .inValid  (pushNow),
        .inData   (stage_nxt),
        .inReady  (fifoInReady),
        .outValid (fifoOutValid),
        .outData  (fifoOutData),
        .outReady (fifoPop)
    );

    assign pushNow = clkRise && pinNow.clrN;                 // see (R5)
    assign fifoPop = fifoOutValid && (!word_r.valid || wordReady);

    always_comb begin
        ready_nxt = fifoInReady;
        word_nxt  = word_r;
        if (fifoPop) begin
            word_nxt.valid = 1'b1;
            word_nxt.data  = fifoOutData;
        end else if (wordReady) begin
            word_nxt.valid = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_r <= 1'b0;
            word_r  <= '{valid: 1'b0, data: WORD_RST};
        end else begin
            ready_r <= ready_nxt;
            word_r  <= word_nxt;
        end
    end

    assign captureReady = ready_r;
    assign wordOut      = word_r;

    //////////////////////////////////////////////////////////////////////////
    // checks

    logic [6:0] lowStages;
    logic       preTail;
    logic       aSeen;
    logic       bSeen;
    assign lowStages = stage_r[6:0];
    assign preTail   = stage_r[6];
    assign aSeen     = pinNow.serA;
    assign bSeen     = pinNow.serB;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    stage_hold_a: assert property ( // see (R6)
        (!clkRise && anyRstN) ##1 anyRstN |-> stage_r == $past(stage_r))
        else $error("stages changed without a shift edge");

    first_load_a: assert property ( // see (R2)
        (clkRise && anyRstN) ##1 anyRstN |-> stage_r[0] == $past(gateBit))
        else $error("first stage did not load the gated input");

    gate_low_a: assert property ( // see (R2)
        (clkRise && !gateBit && anyRstN) ##1 anyRstN |-> !stage_r[0])
        else $error("low serial input did not load a low");

    enable_pass_a: assert property ( // see (R3)
        (clkRise && aSeen && anyRstN) ##1 anyRstN
            |-> stage_r[0] == $past(bSeen))
        else $error("enabled input did not decide the first stage");

    shift_move_a: assert property ( // see (R4)
        (clkRise && anyRstN) ##1 anyRstN
            |-> stage_r[7:1] == $past(lowStages))
        else $error("stages did not shift by one");

    clear_zero_a: assert property ( // see (R5)
        !pinIn.clrN |-> stage_r == STAGE_RST && parOut == 8'h00)
        else $error("clear did not force the stages low");

    serial_tail_a: assert property ( // see (R8)
        (clkRise && anyRstN) ##1 anyRstN |-> serOut == $past(preTail))
        else $error("serial output did not follow the seventh stage");

    edge_once_a: assert property ( // see (R7)
        clkRise |=> !clkRise ##1 !clkRise)
        else $error("one shift clock edge counted twice");

    gate_high_a: assert property ( // see (R2)
        (clkRise && gateBit && anyRstN) ##1 anyRstN |-> stage_r[0])
        else $error("high serial inputs did not load a high");

    enable_swap_a: assert property ( // see (R3)
        (clkRise && bSeen && anyRstN) ##1 anyRstN
            |-> stage_r[0] == $past(aSeen))
        else $error("second input did not let the first one decide");

    word_hold_a: assert property ( // buffered word holds until it is taken
        wordOut.valid && !wordReady
            |=> wordOut.valid && wordOut.data == $past(wordOut.data))
        else $error("waiting word changed before it was taken");

endmodule // serial_in_parallel_out_shift8

`default_nettype wire

/* testbench/upstream_model.sv */
`default_nettype none

module upstream_model (
    // clock
    input  wire logic         core_clk,
    // pins toward the shift register
    output var sipo_pkg::pin_in_t pinIn
);
    timeunit 1ns;
    timeprecision 1ns;
    import sipo_pkg::*;

    initial pinIn = '{clrN: 1'b1, shiftClk: 1'b0, serA: 1'b0, serB: 1'b0};

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge core_clk);
            #1;
        end
    endtask

    task automatic setClr(input logic v);
        pinIn.clrN = v;
    endtask

    // data flips after the rise to show only the edge value counts
    task automatic shiftBit(input logic a, input logic b);
        pinIn.serA = a;
        pinIn.serB = b;
        tick(2);
        pinIn.shiftClk = 1'b1;
        tick(1);
        pinIn.serA = ~a;
        pinIn.serB = ~b;
        tick(2);
        pinIn.shiftClk = 1'b0;
        tick(3);
    endtask

    // serial inputs move, clock stays low
    task automatic wiggle(input int n);
        repeat (n) begin
            pinIn.serA = ~pinIn.serA;
            pinIn.serB = pinIn.serA;
            tick(1);
        end
    endtask
endmodule // upstream_model

`default_nettype wire

/* testbench/serial_in_parallel_out_shift8_test.sv */
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    fail_count++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end

module serial_in_parallel_out_shift8_test;
    timeunit 1ns;
    timeprecision 1ns;
    import sipo_pkg::*;

    logic       core_clk;
    logic       rst_n;
    pin_in_t    pinIn;
    logic [7:0] parOut;
    logic       serOut;
    logic       captureReady;
    word_t      wordOut;
    logic       wordReady;
    logic [7:0] expQ;
    logic [7:0] words[$];
    int         fail_count;
    int         n_checks;

    upstream_model up (.core_clk(core_clk), .pinIn(pinIn));

    serial_in_parallel_out_shift8 #(.DEPTH(FIFO_DEPTH)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .pinIn(pinIn),
        .parOut(parOut), .serOut(serOut), .captureReady(captureReady),
        .wordOut(wordOut), .wordReady(wordReady));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic sh(input logic a, input logic b);
        up.shiftBit(a, b);
        expQ = {expQ[6:0], a & b};
        words.push_back(expQ);
        `CHK("parOut", expQ, parOut)
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_fifo();
        int got;
        got = 0;
        `CHK("ready", 1'b1, captureReady)
        for (int i = 0; i < 9; i++) sh(i % 3 != 0, 1'b1);
        `CHK("full", 1'b0, captureReady)
        for (int c = 0; c < 60 && got < 9; c++) begin
            wordReady = c[0];
            if (wordOut.valid === 1'b1 && wordReady) begin
                `CHK("word", words.pop_front(), wordOut.data)
                got++;
            end
            up.tick(1);
        end
        wordReady = 1'b1;
        `CHK("count", 9, got)
        `CHK("ready2", 1'b1, captureReady)
    endtask

    task automatic t_gate();
        for (int i = 0; i < 4; i++) sh(i[1], i[0]);
    endtask

    task automatic t_hold();
        logic [7:0] p;
        p = parOut;
        up.wiggle(6);
        `CHK("hold", p, parOut)
    endtask

    task automatic t_clear();
        up.setClr(1'b0);
        #1;
        `CHK("clr", 8'h00, parOut)
        up.tick(1);
        up.shiftBit(1'b1, 1'b1);
        `CHK("clrclk", 8'h00, parOut)
        up.setClr(1'b1);
        expQ = 8'h00;
        up.tick(2);
    endtask

    task automatic t_eight();
        sh(1'b1, 1'b1);
        repeat (7) sh(1'b0, 1'b1);
        `CHK("serOut", 1'b1, serOut)
        `CHK("word8", 8'h80, parOut)
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        fail_count = 0;
        n_checks = 0;
        expQ = 8'h00;
        rst_n = 1'b0;
        wordReady = 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        up.tick(2);
        t_fifo();
        words.delete();
        t_gate();
        t_hold();
        t_clear();
        t_eight();
        conclude();
    end

    initial begin
        #(20000 * 40);
        fail_count++;
        conclude();
    end
endmodule // serial_in_parallel_out_shift8_test

`default_nettype wire
